// ---- hdl/iws_defs.vh ----
/*
  iws_defs.vh: register offsets, field positions, reset values and timing
  counts for the audio word-format and dma request block.
  Assumes it is included by bare name into plain verilog design files.
*/
`ifndef IWS_DEFS_VH
`define IWS_DEFS_VH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define IWS_ADDR_W          8
`define IWS_OFS_PORT_CTRL   8'h00
`define IWS_OFS_FORMAT      8'h10
`define IWS_OFS_DMA         8'h30
`define IWS_OFS_FIFO        8'h40

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define IWS_ROLE_HI         7
`define IWS_ROLE_LO         6
`define IWS_ADJ_BIT         15
`define IWS_SMP_HI          13
`define IWS_SMP_LO          9
`define IWS_EN_BIT          8
`define IWS_BW_HI           4
`define IWS_BW_LO           0
`define IWS_RXLVL_HI        31
`define IWS_RXLVL_LO        24
`define IWS_TXLVL_HI        23
`define IWS_TXLVL_LO        16
`define IWS_RXEN_BIT        15
`define IWS_RXTHD_HI        14
`define IWS_RXTHD_LO        8
`define IWS_TXEN_BIT        7
`define IWS_TXTHD_HI        6
`define IWS_TXTHD_LO        0

// ----------------------------------------------------------------------
// encodings and reset values
// ----------------------------------------------------------------------
`define IWS_ROLE_MASTER     2'h0
`define IWS_ROLE_SLAVE      2'h3
`define IWS_ROLE_RST        2'h0
`define IWS_SMP_RST         5'h00
`define IWS_BW_RST          5'h00
`define IWS_THD_RST         7'h00
`define IWS_TX_THD_VAL      7'h00
`define IWS_WORD_ZERO       32'h0000_0000
`define IWS_WORD_ONES       32'hFFFF_FFFF
`define IWS_MSB_POS         5'h1F

// ----------------------------------------------------------------------
// fifo shape and timing
// ----------------------------------------------------------------------
`define IWS_FIFO_AW         5
`define IWS_FIFO_DEPTH      8'h20
`define IWS_BCLK_HALF_NS    80
`define IWS_CLK_NS          20
`define IWS_BCLK_HALF_CYC   (`IWS_BCLK_HALF_NS / `IWS_CLK_NS)

`endif

// ---- hdl/iws_fifo.v ----
/*
  iws_fifo.v: 32-bit wide word fifo with a fill count, used for both the
  transmit and the receive direction.
  Assumes push and pop come from logic on the same clock; a push while full
  and a pop while empty are ignored.
*/
`timescale 1ns/1ns
`include "iws_defs.vh"

module iws_fifo (
  input  wire        clk_sys,
  input  wire        arst_n,
  input  wire        push,
  input  wire [31:0] din,
  input  wire        pop,
  output wire [31:0] dout,
  output reg  [7:0]  level,
  output wire        full,
  output wire        empty
);

  reg  [31:0]               mem [0:`IWS_FIFO_DEPTH-1];
  reg  [`IWS_FIFO_AW-1:0]   wr_ptr;
  reg  [`IWS_FIFO_AW-1:0]   rd_ptr;
  wire                      do_push;
  wire                      do_pop;

  // ----------------------------------------------------------------------
  // status and guarded strobes
  // ----------------------------------------------------------------------
  assign full    = (level == `IWS_FIFO_DEPTH);
  assign empty   = (level == 8'h00);
  assign do_push = push & ~full;   // a push while full is dropped
  assign do_pop  = pop & ~empty;
  assign dout    = empty ? `IWS_WORD_ZERO : mem[rd_ptr];

  // storage has no reset so it can map to plain ram
  always @(posedge clk_sys) begin
    if (do_push) begin
      mem[wr_ptr] <= din;
    end
  end

  // pointers and count; push and pop together leave the count alone
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= {`IWS_FIFO_AW{1'b0}};
      rd_ptr <= {`IWS_FIFO_AW{1'b0}};
      level  <= 8'h00;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_push & ~do_pop) begin
        level <= level + 8'h01;
      end else if (do_pop & ~do_push) begin
        level <= level - 8'h01;
      end
    end
  end

endmodule // iws_fifo

// ---- hdl/iws_top.v ----
/*
  iws_top.v: word format, serial shifting, fifo levels and dma requests of
  a two-channel audio serial port, with its register file.
  Assumes a single-cycle register port on clk_sys, an external converter on
  the serial pins and a system dma that watches the two request levels.
*/
// Local design decision: the address-and-strobe port.
// Overview of operation
// - shorter sample sits in upper word bits if adjust is 0, lower if 1
// - five-bit sample size field sets sample bits within each word
// - sample size zero or above word length means sample equals word length
// - master: enable starts bit and frame clock outputs, clearing stops them
// - slave: enable starts accepting external clocks and data
// - word length field is bit clocks per half-frame minus one
// - read-only eight-bit receive fifo count
// - read-only eight-bit transmit fifo count
// - receive dma channel enable bit, 1 enables
// - receive dma request while receive count exceeds receive threshold
// - transmit dma channel enable bit, 1 enables
// - transmit dma request while transmit count below read-only threshold
// - role 0 is master with internal clocks, role 3 is slave
// - data port write while transmit fifo full is dropped, else pushed
// - data port read returns oldest receive word and pops it
`timescale 1ns/1ns
`include "iws_defs.vh"

module iws_top (
  input  wire                   clk_sys,
  input  wire                   arst_n,
  input  wire [`IWS_ADDR_W-1:0] addr,
  input  wire [31:0]            wr_data,
  input  wire                   wr_en,
  input  wire                   rd_en,
  output reg  [31:0]            rd_data,
  input  wire                   bclk_in,
  output reg                    bclk_out,
  output reg                    bclk_oe_n,
  input  wire                   lrclk_in,
  output reg                    lrclk_out,
  output reg                    lrclk_oe_n,
  input  wire                   sdi,
  output reg                    sdo,
  output reg                    dma_rx_req,
  output reg                    dma_tx_req
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  reg  [1:0]  port_role;
  reg         adjust;
  reg  [4:0]  smp_size;
  reg         port_en;
  reg  [4:0]  bits_word;
  reg         rx_dma_en;
  reg  [6:0]  rx_thd;
  reg         tx_dma_en;
  reg  [6:0]  tx_thd;
  reg  [2:0]  pin_s1;
  reg  [2:0]  pin_s2;
  reg  [2:0]  pin_s3;
  reg  [3:0]  div_cnt;
  reg         started;
  reg         lr_prev;
  reg  [4:0]  tx_cnt;
  reg  [4:0]  rx_cnt;
  reg  [31:0] tx_shift;
  reg  [31:0] rx_shift;
  reg  [31:0] next_rd_data;
  wire        is_master;
  wire        active;
  wire        m_tick;
  wire        evt_rise;
  wire        evt_fall;
  wire        half_start;
  wire [4:0]  s_eff;
  wire [4:0]  pad;
  wire [31:0] smp_mask;
  wire [31:0] word_mask;
  wire [31:0] tx_sample;
  wire [31:0] tx_load;
  wire [31:0] rx_next;
  wire [31:0] rx_word;
  wire [31:0] rx_sample;
  wire        rx_push;
  wire        tx_pop;
  wire        bus_push;
  wire        bus_pop;
  wire [31:0] tx_dout;
  wire [31:0] rx_dout;
  wire [7:0]  tx_lvl;
  wire [7:0]  rx_lvl;
  wire        tx_full;
  wire        tx_empty;
  wire        rx_full;
  wire        rx_empty;

  // ----------------------------------------------------------------------
  // role and enable
  // ----------------------------------------------------------------------
  // role decode
  assign is_master = (port_role == `IWS_ROLE_MASTER);
  assign active    = port_en & (is_master | (port_role == `IWS_ROLE_SLAVE));

  // ----------------------------------------------------------------------
  // sample size arithmetic
  // ----------------------------------------------------------------------
  // effective sample size
  assign s_eff     = ((smp_size == `IWS_SMP_RST) || (smp_size > bits_word)) ?
                     bits_word : smp_size;
  assign pad       = bits_word - s_eff;
  assign smp_mask  = ~(`IWS_WORD_ONES << ({1'b0, s_eff} + 6'h01));
  assign word_mask = ~(`IWS_WORD_ONES << ({1'b0, bits_word} + 6'h01));

  // ----------------------------------------------------------------------
  // pin synchronisers: bit 0 bit clock, bit 1 frame clock, bit 2 data
  // ----------------------------------------------------------------------
  // s3 is only an edge-history copy of s2, s1 feeds s2 alone
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_s3 <= 3'h0;
    end else begin
      pin_s1 <= {sdi, lrclk_in, bclk_in};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // ----------------------------------------------------------------------
  // bit clock events
  // ----------------------------------------------------------------------
  // master ticks from the divider, slave from synchronised pin edges
  assign m_tick   = active & is_master & (div_cnt == (`IWS_BCLK_HALF_CYC - 1));
  assign evt_rise = is_master ? (m_tick & ~bclk_out) :
                    (active & pin_s2[0] & ~pin_s3[0]);
  assign evt_fall = is_master ? (m_tick & bclk_out) :
                    (active & ~pin_s2[0] & pin_s3[0]);
  // a new half-frame starts on a falling edge
  assign half_start = is_master ? (~started | (tx_cnt == bits_word)) :
                      (~started | (pin_s2[1] != lr_prev));

  // ----------------------------------------------------------------------
  // justification of words in both directions
  // ----------------------------------------------------------------------
  // transmit placement in word
  assign tx_sample = tx_dout & smp_mask;
  assign tx_load   = adjust ? (tx_sample << (`IWS_MSB_POS - bits_word)) :
                     (tx_sample << (`IWS_MSB_POS - s_eff));
  assign rx_next   = {rx_shift[30:0], pin_s2[2]};
  assign rx_word   = rx_next & word_mask;
  assign rx_sample = adjust ? (rx_word & smp_mask) : (rx_word >> pad);

  // ----------------------------------------------------------------------
  // fifo strobes
  // ----------------------------------------------------------------------
  assign tx_pop   = evt_fall & half_start & ~tx_empty;
  assign rx_push  = evt_rise & started & (rx_cnt == bits_word);
  assign bus_push = wr_en & (addr == `IWS_OFS_FIFO);
  assign bus_pop  = rd_en & (addr == `IWS_OFS_FIFO);

  iws_fifo u_tx_fifo (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .push    (bus_push),
    .din     (wr_data),
    .pop     (tx_pop),
    .dout    (tx_dout),
    .level   (tx_lvl),
    .full    (tx_full),
    .empty   (tx_empty)
  );

  iws_fifo u_rx_fifo (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .push    (rx_push),
    .din     (rx_sample),
    .pop     (bus_pop),
    .dout    (rx_dout),
    .level   (rx_lvl),
    .full    (rx_full),
    .empty   (rx_empty)
  );

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  // transmit threshold is read-only and keeps its fixed value
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      port_role <= `IWS_ROLE_RST;
      adjust    <= 1'b0;
      smp_size  <= `IWS_SMP_RST;
      port_en   <= 1'b0;
      bits_word <= `IWS_BW_RST;
      rx_dma_en <= 1'b0;
      rx_thd    <= `IWS_THD_RST;
      tx_dma_en <= 1'b0;
      tx_thd    <= `IWS_TX_THD_VAL;
    end else if (wr_en) begin
      case (addr)
        `IWS_OFS_PORT_CTRL: begin
          port_role <= wr_data[`IWS_ROLE_HI:`IWS_ROLE_LO];
        end
        `IWS_OFS_FORMAT: begin
          adjust    <= wr_data[`IWS_ADJ_BIT];
          smp_size  <= wr_data[`IWS_SMP_HI:`IWS_SMP_LO];
          port_en   <= wr_data[`IWS_EN_BIT];
          bits_word <= wr_data[`IWS_BW_HI:`IWS_BW_LO];
        end
        `IWS_OFS_DMA: begin
          rx_dma_en <= wr_data[`IWS_RXEN_BIT];
          rx_thd    <= wr_data[`IWS_RXTHD_HI:`IWS_RXTHD_LO];
          tx_dma_en <= wr_data[`IWS_TXEN_BIT];
        end
        default: begin
          tx_thd <= tx_thd;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------------
  always @* begin
    next_rd_data = `IWS_WORD_ZERO;
    case (addr)
      `IWS_OFS_PORT_CTRL: begin
        next_rd_data[`IWS_ROLE_HI:`IWS_ROLE_LO] = port_role;
      end
      `IWS_OFS_FORMAT: begin
        next_rd_data[`IWS_ADJ_BIT]             = adjust;
        next_rd_data[`IWS_SMP_HI:`IWS_SMP_LO]  = smp_size;
        next_rd_data[`IWS_EN_BIT]              = port_en;
        next_rd_data[`IWS_BW_HI:`IWS_BW_LO]    = bits_word;
      end
      `IWS_OFS_DMA: begin
        next_rd_data[`IWS_RXLVL_HI:`IWS_RXLVL_LO] = rx_lvl;
        next_rd_data[`IWS_TXLVL_HI:`IWS_TXLVL_LO] = tx_lvl;
        next_rd_data[`IWS_RXEN_BIT]               = rx_dma_en;
        next_rd_data[`IWS_RXTHD_HI:`IWS_RXTHD_LO] = rx_thd;
        next_rd_data[`IWS_TXEN_BIT]               = tx_dma_en;
        next_rd_data[`IWS_TXTHD_HI:`IWS_TXTHD_LO] = tx_thd;
      end
      `IWS_OFS_FIFO: begin
        next_rd_data = rx_dout;   // zero when the receive fifo is empty
      end
      default: begin
        next_rd_data = `IWS_WORD_ZERO;
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= `IWS_WORD_ZERO;
    end else begin
      rd_data <= rd_en ? next_rd_data : `IWS_WORD_ZERO;
    end
  end

  // ----------------------------------------------------------------------
  // clock generation and pin direction
  // ----------------------------------------------------------------------
  // master clocks run only while enabled
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt    <= 4'h0;
      bclk_out   <= 1'b0;
      lrclk_out  <= 1'b0;
      bclk_oe_n  <= 1'b1;
      lrclk_oe_n <= 1'b1;
    end else begin
      bclk_oe_n  <= ~is_master;   // drive clock pins only as master
      lrclk_oe_n <= ~is_master;
      if (!(active & is_master)) begin
        div_cnt   <= 4'h0;
        bclk_out  <= 1'b0;
        lrclk_out <= 1'b0;
      end else if (m_tick) begin
        div_cnt  <= 4'h0;
        bclk_out <= ~bclk_out;
        // frame clock flips on the fall that ends a half-frame
        if (bclk_out & started & (tx_cnt == bits_word)) begin
          lrclk_out <= ~lrclk_out;
        end
      end else begin
        div_cnt <= div_cnt + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // serial shifting
  // ----------------------------------------------------------------------
  // bit counters span word length
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      started  <= 1'b0;
      lr_prev  <= 1'b0;
      tx_cnt   <= 5'h00;
      rx_cnt   <= 5'h00;
      tx_shift <= `IWS_WORD_ZERO;
      rx_shift <= `IWS_WORD_ZERO;
      sdo      <= 1'b0;
    end else if (!active) begin
      started  <= 1'b0;
      tx_cnt   <= 5'h00;
      rx_cnt   <= 5'h00;
      sdo      <= 1'b0;
    end else begin
      if (evt_fall) begin
        started <= 1'b1;
        lr_prev <= pin_s2[1];
        if (half_start) begin
          // an empty transmit fifo sends silence rather than stale data
          tx_cnt   <= 5'h00;
          rx_cnt   <= 5'h00;
          sdo      <= tx_empty ? 1'b0 : tx_load[31];
          tx_shift <= tx_empty ? `IWS_WORD_ZERO : {tx_load[30:0], 1'b0};
        end else begin
          tx_cnt   <= tx_cnt + 5'h01;
          sdo      <= tx_shift[31];
          tx_shift <= {tx_shift[30:0], 1'b0};
        end
      end
      if (evt_rise & started) begin
        rx_shift <= rx_next;
        rx_cnt   <= rx_cnt + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // dma requests
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dma_rx_req <= 1'b0;
      dma_tx_req <= 1'b0;
    end else begin
      dma_rx_req <= rx_dma_en & (rx_lvl > {1'b0, rx_thd});
      dma_tx_req <= tx_dma_en & (tx_lvl < {1'b0, tx_thd});
    end
  end

endmodule // iws_top

// ---- sim/iws_codec.sv ----
/*
  iws_codec.sv: external converter model; sends a fixed byte pattern MSB
  first, records the first byte received, and makes the clocks in slave role.
  Assumes eight bits per half-frame and a reset pulse before each run.
*/
`timescale 1ns/1ns

module iws_codec #(
  parameter logic [7:0] PAT = 8'hA5
) (
  input  wire        bclk,
  input  wire        sdo,
  input  wire        rst,
  input  wire        gen,
  output logic       bclk_drv,
  output logic       lrclk_drv,
  output logic       sdi,
  output logic [7:0] first_rx
);
  int   cnt;
  int   nrx;
  logic seen;

  // bit clock, runs only inside a wanted frame and stands low outside
  initial begin
    bclk_drv = 1'b0;
    #7;
    forever #80 bclk_drv = gen ? ~bclk_drv : 1'b0;
  end

  // data on falls, frame clock flips at each half-frame start
  always @(negedge bclk or posedge rst) begin
    if (rst) begin
      cnt       <= 0;
      seen      <= 1'b0;
      sdi       <= 1'b0;
      lrclk_drv <= 1'b0;
    end else begin
      sdi  <= PAT[7-cnt];
      cnt  <= (cnt + 1) % 8;
      seen <= 1'b1;
      if (gen && cnt == 0)
        lrclk_drv <= ~lrclk_drv;
    end
  end

  // first byte after the first fall; the rise before it carries nothing
  always @(posedge bclk or posedge rst) begin
    if (rst)
      nrx <= 0;
    else if (seen && nrx < 8) begin
      first_rx <= {first_rx[6:0], sdo};
      nrx      <= nrx + 1;
    end
  end
endmodule // iws_codec

// ---- sim/iws_props.sv ----
/*
  iws_props.sv: port-level assertions for the audio word-format block.
  Assumes it is bound to iws_top and sees only clk_sys domain ports.
*/
`timescale 1ns/1ns
`include "iws_defs.vh"

module iws_props (
  input wire                   clk_sys,
  input wire                   arst_n,
  input wire [`IWS_ADDR_W-1:0] addr,
  input wire [31:0]            wr_data,
  input wire                   wr_en,
  input wire                   rd_en,
  input wire [31:0]            rd_data,
  input wire                   bclk_in,
  input wire                   bclk_out,
  input wire                   bclk_oe_n,
  input wire                   lrclk_in,
  input wire                   lrclk_out,
  input wire                   lrclk_oe_n,
  input wire                   sdi,
  input wire                   sdo,
  input wire                   dma_rx_req,
  input wire                   dma_tx_req
);
  logic       en_q;
  logic [1:0] role_q;

  // shadow of enable and role, landing on the same edge as the register
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      en_q   <= 1'b0;
      role_q <= 2'h0;
    end else if (wr_en) begin
      if (addr == `IWS_OFS_FORMAT)
        en_q <= wr_data[`IWS_EN_BIT];
      if (addr == `IWS_OFS_PORT_CTRL)
        role_q <= wr_data[7:6];
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // half bit of four clocks, or cut short by a disable
  sequence s_high4; bclk_out[*4] ##1 !bclk_out; endsequence
  sequence s_stop; ##[0:5] !en_q; endsequence
  sequence s_rx_off; wr_en && addr == `IWS_OFS_DMA && !wr_data[`IWS_RXEN_BIT]; endsequence

  property p_rd_idle; !$past(rd_en) |-> rd_data == `IWS_WORD_ZERO; endproperty
  property p_tx_never; !dma_tx_req; endproperty
  property p_rx_off; s_rx_off |-> ##2 !dma_rx_req; endproperty
  property p_role_oe;
    wr_en && addr == `IWS_OFS_PORT_CTRL |->
      ##2 (bclk_oe_n == ($past(wr_data[7:6], 2) != 2'h0)) && (lrclk_oe_n == bclk_oe_n);
  endproperty
  property p_idle; !en_q && !$past(en_q) && !$past(en_q, 2) |-> !bclk_out && !lrclk_out;
  endproperty
  property p_start; $rose(en_q) && role_q == 2'h0 |-> ##[1:8] $rose(bclk_out); endproperty
  property p_bclk_rate; $rose(bclk_out) |-> s_high4 or s_stop; endproperty
  property p_lr_edge;
    role_q == 2'h0 && en_q && $past(en_q) && $changed(lrclk_out) |-> $fell(bclk_out);
  endproperty
  property p_sdo_edge;
    role_q == 2'h0 && en_q && $past(en_q) && $changed(sdo) |-> $fell(bclk_out);
  endproperty

  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside read cycle");
  a_tx_never: assert property (p_tx_never)
    else $error("transmit request with zero threshold");
  a_rx_off: assert property (p_rx_off)
    else $error("receive request while channel disabled");
  a_role_oe: assert property (p_role_oe)
    else $error("clock output enables do not follow role");
  a_idle: assert property (p_idle)
    else $error("clocks move while disabled");
  a_start: assert property (p_start)
    else $error("bit clock did not start after enable");
  a_bclk_rate: assert property (p_bclk_rate)
    else $error("bit clock high time not four cycles");
  a_lr_edge: assert property (p_lr_edge)
    else $error("frame clock moved off a bit clock fall");
  a_sdo_edge: assert property (p_sdo_edge)
    else $error("serial out moved off a bit clock fall");
endmodule // iws_props

// ---- sim/iws_top_tb.sv ----
/*
  iws_top_tb.sv: register-driven tests of the audio word-format block.
  Assumes iws_top, the codec model and the checker bound below.
*/
`timescale 1ns/1ns
`include "iws_defs.vh"

module iws_top_tb;
  logic        clk_sys, arst_n, wr_en, rd_en, rst_c, gen;
  logic [7:0]  addr;
  logic [31:0] wr_data, got;
  wire  [31:0] rd_data;
  wire  [7:0]  c_first;
  wire         bclk_out, bclk_oe_n, lrclk_out, lrclk_oe_n, sdi, sdo;
  wire         dma_rx_req, dma_tx_req, c_bclk, c_lr, bclk_w, lr_w;
  int          n_errors, n_compared;
  logic [31:0] exp_t [4] = '{32'h0000_00A5, 32'h0000_000A, 32'h0000_0005, 32'h0000_00A5};
  logic [31:0] fmt_t [4] = '{32'h0000_0107, 32'h0000_0707, 32'h0000_8707, 32'h0000_1307};

  // pin level: the dut drives it while its enable is low, the codec otherwise
  assign bclk_w = bclk_oe_n ? c_bclk : bclk_out;
  assign lr_w   = lrclk_oe_n ? c_lr : lrclk_out;

  iws_top dut (.clk_sys, .arst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
    .bclk_in(bclk_w), .bclk_out, .bclk_oe_n, .lrclk_in(lr_w), .lrclk_out, .lrclk_oe_n,
    .sdi, .sdo, .dma_rx_req, .dma_tx_req);
  iws_codec u_codec (.bclk(bclk_w), .sdo, .rst(rst_c), .gen, .bclk_drv(c_bclk),
    .lrclk_drv(c_lr), .sdi, .first_rx(c_first));

  task automatic stop_test();
    $display("compared %0d, wrong %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, g, e);
    end
  endtask

  // one-cycle strobes, changed just after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 got = rd_data;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    cmp(got, e);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  task automatic restart();
    rst_c <= 1'b1;
    @(posedge clk_sys);
    rst_c <= 1'b0;
  endtask

  // poll the receive level with a bounded count of reads
  task automatic wait_rx(input int lvl);
    int i;
    rd(`IWS_OFS_DMA);
    for (i = 0; i < 3000 && got[31:24] < lvl; i++)
      rd(`IWS_OFS_DMA);
    if (i == 3000) begin
      n_errors++;
      $display("wrong value at %0t ns: receive level never reached", $time);
      stop_test();
    end
  endtask

  task automatic drain(input logic [31:0] e);
    int n;
    rd(`IWS_OFS_DMA);
    n = got[31:24];
    repeat (n) rdc(`IWS_OFS_FIFO, e);
    rdc(`IWS_OFS_FIFO, `IWS_WORD_ZERO);
    rdc(`IWS_OFS_DMA, 32'h0000_1F00);
    cmp(32'(got[31:24]), 32'h0000_0000);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // guard against a hang outside the bounded loops
  initial begin
    #1_500_000;
    n_errors++;
    $display("wrong value at %0t ns: run did not finish", $time);
    stop_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {arst_n, wr_en, rd_en, gen, addr, wr_data} = '0;
    rst_c      = 1'b1;
    n_errors   = 0;
    n_compared = 0;
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    rst_c  <= 1'b0;
    rdc(`IWS_OFS_PORT_CTRL, 32'h0000_0000);
    rdc(`IWS_OFS_FORMAT, 32'h0000_0000);
    rdc(`IWS_OFS_DMA, 32'h0000_0000);
    wr(`IWS_OFS_FORMAT, 32'hFFFF_FEFF);
    rdc(`IWS_OFS_FORMAT, 32'h0000_BE1F);
    wr(`IWS_OFS_DMA, 32'hFFFF_FFFF);
    rdc(`IWS_OFS_DMA, 32'h0000_FF80);
    cmp(32'(dma_tx_req), 32'h0);
    wr(8'h20, 32'hFFFF_FFFF);
    rdc(8'h20, 32'h0000_0000);
    wr(`IWS_OFS_DMA, 32'h0000_0000);
    wr(`IWS_OFS_FORMAT, 32'h0000_0000);
    $display("test registers done");
    for (int i = 0; i < 33; i++)
      wr(`IWS_OFS_FIFO, 32'h3C + i);
    rdc(`IWS_OFS_DMA, 32'h0020_0000);
    wr(`IWS_OFS_DMA, 32'hFFFF_0000);
    rdc(`IWS_OFS_DMA, 32'h0020_0000);
    $display("test transmit fill done");
    for (int k = 0; k < 4; k++) begin
      restart();
      wr(`IWS_OFS_FORMAT, fmt_t[k]);
      wait_rx(32);
      repeat (200) @(posedge clk_sys);
      wr(`IWS_OFS_FORMAT, 32'h0000_0000);
      rd(`IWS_OFS_DMA);
      cmp(got & 32'hFFFF_0000, 32'h2000_0000);
      if (k == 0)
        cmp(32'(c_first), 32'h0000_003C);
      wr(`IWS_OFS_DMA, 32'h0000_9F00);
      settle();
      cmp(32'(dma_rx_req), 32'h1);
      wr(`IWS_OFS_DMA, 32'h0000_A000);
      settle();
      cmp(32'(dma_rx_req), 32'h0);
      wr(`IWS_OFS_DMA, 32'h0000_1F00);
      settle();
      cmp(32'(dma_rx_req), 32'h0);
      drain(exp_t[k]);
      $display("test master format %0d done", k);
    end
    wr(`IWS_OFS_PORT_CTRL, 32'h0000_00C0);
    settle();
    cmp(32'({bclk_oe_n, lrclk_oe_n}), 32'h3);
    restart();
    wr(`IWS_OFS_FORMAT, 32'h0000_0107);
    gen <= 1'b1;
    wait_rx(4);
    gen <= 1'b0;
    wr(`IWS_OFS_FORMAT, 32'h0000_0000);
    drain(32'h0000_00A5);
    wr(`IWS_OFS_PORT_CTRL, 32'h0000_0000);
    $display("test slave receive done");
    stop_test();
  end
endmodule // iws_top_tb

bind iws_top iws_props u_props (
  .clk_sys, .arst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .bclk_in, .bclk_out,
  .bclk_oe_n, .lrclk_in, .lrclk_out, .lrclk_oe_n, .sdi, .sdo, .dma_rx_req, .dma_tx_req
);
